/* hw/esa_pkg.sv */
package esa_pkg;

	// ==========================================
	// Error byte layout
	localparam int BIT_FATAL    = 0;
	localparam int BIT_OFFSET   = 1;
	localparam int BIT_CONFIG   = 2;
	localparam int BIT_OUTPUT   = 3;
	localparam int BIT_SELFDIAG = 4;
	localparam int BIT_RANGE    = 5;
	localparam int BIT_MEMORY   = 6;
	localparam int BIT_RESERVED = 7;
	localparam int NUM_PROBES   = 4;
	localparam int PROBE_W      = 16;

	localparam logic [7:0] ERR_RESET    = 8'h00;
	localparam logic [7:0] ERR_AUTO     = 8'h22;
	localparam logic [7:0] ERR_LATCH    = 8'h5d;
	localparam logic [7:0] ERR_NONE     = 8'h00;

	// ==========================================
	// Self-test timing
	localparam int          SELFTEST_NS   = 1000;
	localparam int          CLK_NS        = 25;
	localparam int          SELFTEST_CYC  = (SELFTEST_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0]  SELFTEST_LAST = 8'(SELFTEST_CYC - 1);
	localparam logic [7:0]  CNT_ZERO      = 8'h00;
	localparam logic [7:0]  CNT_ONE       = 8'h01;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic [PROBE_W-1:0] value;
		logic [PROBE_W-1:0] low;
		logic [PROBE_W-1:0] high;
	} esa_probe_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} esa_nvm_wr_t;

	typedef struct packed {
		logic fatal;
		logic offset;
		logic config_bad;
		logic output_bad;
		logic selfdiag;
		logic memory;
	} esa_faults_t;

endpackage : esa_pkg

/* hw/esa_range_check.sv */
`timescale 1ns/1ps
module esa_range_check (
	input  wire logic                             clk,
	input  wire logic                             rst,
	input  wire esa_pkg::esa_probe_t              probe [esa_pkg::NUM_PROBES],
	output logic                                  outOfRange
);
	import esa_pkg::*;

	logic [NUM_PROBES-1:0] bad;
	logic                  next_outOfRange;

	// ==========================================
	// Per-probe window compare
	genvar g;
	generate
		for (g = 0; g < NUM_PROBES; g++) begin : g_probe
			assign bad[g] = (probe[g].value < probe[g].low) ||
			                (probe[g].value > probe[g].high);
		end
	endgenerate

	always_comb begin
		next_outOfRange = |bad;
	end

	always_ff @(posedge clk) begin
		if (rst)
			outOfRange <= 1'b0;
		else
			outOfRange <= next_outOfRange;
	end

endmodule : esa_range_check

/* hw/esa_error_status.sv */
`timescale 1ns/1ps
// How it works
// - Self-test after power-up before reporting OK
// - Continuously compare probes against valid ranges
// - Read back each nonvolatile write that arrives while the verify is idle, compare
// - Status high when byte zero after self-test, else low
// - Error byte readable over UART or I2C
// - Offset and range bits clear themselves
// - Bits 0, 2, 3, 4, 6 latched until overwrite or reset; bit 7 always zero
// - Bits 0,1,2: fatal, offset, config
// - Bit 3: output generation error
// - Bit 4: self-diagnostic failure
// - Bit 5: any probe out of range
// - Bit 6 memory error; bit 7 reserved
// - Simultaneous faults combine into one byte
module esa_error_status (
	input  wire logic                             clk,
	input  wire logic                             rst,
	input  wire esa_pkg::esa_probe_t              probe [esa_pkg::NUM_PROBES],
	input  wire esa_pkg::esa_faults_t             faults,
	input  wire esa_pkg::esa_nvm_wr_t             nvmWrite,
	input  wire logic [7:0]                       nvmReadData,
	input  wire logic                             selfTestFail,
	input  wire logic                             uartWrite,
	input  wire logic [7:0]                       uartWriteData,
	output logic                                  nvmReadReq,
	output logic [7:0]                            nvmReadAddr,
	output logic                                  selfTestRun,
	output logic                                  selfTestDone,
	output logic                                  statusOk,
	output logic [7:0]                            uartReadData,
	output logic [7:0]                            i2cReadData
);
	import esa_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_TEST, ST_RUN} esa_state_t;
	typedef enum logic [1:0] {NV_IDLE, NV_READ, NV_CMP} esa_nvstate_t;

	logic        outOfRange;
	esa_state_t  state,  next_state;
	logic [7:0]  cnt,    next_cnt;
	logic        next_selfTestRun;
	logic        next_selfTestDone;
	esa_nvstate_t nvState, next_nvState;
	logic [7:0]  nvAddr,  next_nvAddr;
	logic [7:0]  nvData,  next_nvData;
	logic        next_nvmReadReq;
	logic        memFail;
	logic        testFail;
	logic [7:0]  errorByte, next_errorByte;
	logic [7:0]  setBits;
	logic [7:0]  autoBits;
	logic        next_statusOk;

	// ==========================================
	// Probe range monitor
	esa_range_check u_range (
		.clk        (clk),
		.rst        (rst),
		.probe      (probe),
		.outOfRange (outOfRange)
	);

	// ==========================================
	// Power-up self-test sequencer
	always_comb begin
		next_state        = state;
		next_cnt          = cnt;
		next_selfTestRun  = 1'b0;
		next_selfTestDone = selfTestDone;
		testFail          = 1'b0;
		case (state)
			ST_IDLE: begin
				next_state       = ST_TEST;
				next_cnt         = CNT_ZERO;
				next_selfTestRun = 1'b1;
			end
			ST_TEST: begin
				next_selfTestRun = 1'b1;
				next_cnt         = cnt + CNT_ONE;
				if (cnt == SELFTEST_LAST) begin
					testFail          = selfTestFail;
					next_state        = ST_RUN;
					next_selfTestRun  = 1'b0;
					next_selfTestDone = 1'b1;
				end
			end
			ST_RUN: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state        <= ST_IDLE;
			cnt          <= CNT_ZERO;
			selfTestRun  <= 1'b0;
			selfTestDone <= 1'b0;
		end else begin
			state        <= next_state;
			cnt          <= next_cnt;
			selfTestRun  <= next_selfTestRun;
			selfTestDone <= next_selfTestDone;
		end
	end

	// ==========================================
	// Nonvolatile write verify
	always_comb begin
		next_nvState    = nvState;
		next_nvAddr     = nvAddr;
		next_nvData     = nvData;
		next_nvmReadReq = 1'b0;
		memFail         = 1'b0;
		case (nvState)
			NV_IDLE: begin
				if (nvmWrite.valid) begin
					next_nvAddr     = nvmWrite.addr;
					next_nvData     = nvmWrite.data;
					next_nvmReadReq = 1'b1;
					next_nvState    = NV_READ;
				end
			end
			NV_READ: begin
				next_nvState = NV_CMP;
			end
			NV_CMP: begin
				memFail      = (nvmReadData != nvData);
				next_nvState = NV_IDLE;
			end
			default: begin
				next_nvState = NV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			nvState    <= NV_IDLE;
			nvAddr     <= CNT_ZERO;
			nvData     <= CNT_ZERO;
			nvmReadReq <= 1'b0;
		end else begin
			nvState    <= next_nvState;
			nvAddr     <= next_nvAddr;
			nvData     <= next_nvData;
			nvmReadReq <= next_nvmReadReq;
		end
	end

	assign nvmReadAddr = nvAddr;

	// ==========================================
	// Error byte
	always_comb begin
		setBits               = ERR_NONE;
		setBits[BIT_FATAL]    = faults.fatal | testFail;
		setBits[BIT_CONFIG]   = faults.config_bad;
		setBits[BIT_OUTPUT]   = faults.output_bad;
		setBits[BIT_SELFDIAG] = faults.selfdiag;
		setBits[BIT_MEMORY]   = faults.memory | memFail;
		autoBits              = ERR_NONE;
		autoBits[BIT_OFFSET]  = faults.offset;
		autoBits[BIT_RANGE]   = outOfRange;
		next_errorByte        = errorByte & ERR_LATCH;
		if (uartWrite)
			next_errorByte = uartWriteData & ERR_LATCH;
		next_errorByte = next_errorByte | (setBits & ERR_LATCH) | autoBits;
		next_errorByte[BIT_RESERVED] = 1'b0;
		next_statusOk  = (state == ST_RUN) && (next_errorByte == ERR_NONE);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			errorByte    <= ERR_RESET;
			statusOk     <= 1'b0;
			uartReadData <= ERR_RESET;
			i2cReadData  <= ERR_RESET;
		end else begin
			errorByte    <= next_errorByte;
			statusOk     <= next_statusOk;
			uartReadData <= next_errorByte;
			i2cReadData  <= next_errorByte;
		end
	end

endmodule : esa_error_status

/* verif/esa_error_status_assertions.sv */
`timescale 1ns/1ps
module esa_error_status_assertions (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire esa_pkg::esa_faults_t faults,
	input wire logic                 uartWrite,
	input wire logic                 selfTestDone,
	input wire logic                 statusOk,
	input wire logic [7:0]           uartReadData,
	input wire logic [7:0]           i2cReadData
);
	import esa_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_ok; statusOk |-> uartReadData == 8'h00; endproperty
	a_ok: assert property (p_ok) else $error("ok with errors");
	property p_done; !selfTestDone |-> !statusOk; endproperty
	a_done: assert property (p_done) else $error("ok too early");
	property p_rsv; !uartReadData[7]; endproperty
	a_rsv: assert property (p_rsv) else $error("bit 7 set");
	property p_i2c; i2cReadData == uartReadData; endproperty
	a_i2c: assert property (p_i2c) else $error("ports differ");
	property p_out; faults.output_bad |=> uartReadData[3]; endproperty
	a_out: assert property (p_out) else $error("bit 3 missed");
	property p_hold; uartReadData[3] && !uartWrite |=> uartReadData[3]; endproperty
	a_hold: assert property (p_hold) else $error("bit 3 lost");
	property p_fat; faults.fatal |=> uartReadData[0]; endproperty
	a_fat: assert property (p_fat) else $error("bit 0 missed");
	property p_mem; faults.memory |=> uartReadData[6]; endproperty
	a_mem: assert property (p_mem) else $error("bit 6 missed");
	property p_off; !faults.offset |=> !uartReadData[1]; endproperty
	a_off: assert property (p_off) else $error("bit 1 stuck");
endmodule : esa_error_status_assertions
bind esa_error_status esa_error_status_assertions chk_u (.clk, .rst, .faults,
	.uartWrite, .selfTestDone, .statusOk, .uartReadData, .i2cReadData);

/* verif/esa_nvm_model.sv */
`timescale 1ns/1ps
module esa_nvm_model (
	input  wire logic                 clk,
	input  wire esa_pkg::esa_nvm_wr_t nvmWrite,
	input  wire logic                 nvmReadReq,
	input  wire logic [7:0]           nvmReadAddr,
	input  wire logic                 corrupt,
	output logic [7:0]                nvmReadData
);
	import esa_pkg::*;
	logic [7:0] mem [256];
	always_ff @(posedge clk) begin
		if (nvmWrite.valid) mem[nvmWrite.addr] <= nvmWrite.data;
		if (nvmReadReq) nvmReadData <= mem[nvmReadAddr] ^ {8{corrupt}};
	end
endmodule : esa_nvm_model

/* verif/error_status_aggregator_tb.sv */
`timescale 1ns/1ps
module error_status_aggregator_tb;
	import esa_pkg::*;
	logic        clk, rst, selfTestFail, uartWrite, corrupt, nvmReadReq;
	logic        selfTestRun, selfTestDone, statusOk, oorD;
	logic [7:0]  uartWriteData, nvmReadData, nvmReadAddr, uartReadData, i2cReadData;
	logic [7:0]  lat, expByte;
	logic [31:0] seed;
	esa_probe_t  probe [NUM_PROBES];
	esa_faults_t faults;
	esa_nvm_wr_t nvmWrite;
	int          err_total, cmp_count, cyc, nvd;
	esa_error_status dut_u (.clk, .rst, .probe, .faults, .nvmWrite, .nvmReadData,
		.selfTestFail, .uartWrite, .uartWriteData, .nvmReadReq, .nvmReadAddr,
		.selfTestRun, .selfTestDone, .statusOk, .uartReadData, .i2cReadData);
	esa_nvm_model nvm_u (.clk, .nvmWrite, .nvmReadReq, .nvmReadAddr, .corrupt,
		.nvmReadData);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic step(input logic [5:0] f, input logic uw, input logic [7:0] wd,
		input logic nv);
		logic oor;
		@(negedge clk);
		chk8(uartReadData, expByte);
		chk8(i2cReadData, expByte);
		chk8({7'h0, statusOk}, {7'h0, expByte == 8'h00});
		oor = 1'b0;
		for (int i = 0; i < NUM_PROBES; i++) begin
			seed = xs(seed);
			probe[i].value = seed[15:0];
			oor |= seed[15:0] < 16'h0100 || seed[15:0] > 16'hfeff;
		end
		if (nvd > 0) nvd--;
		if (nv) nvd = 4;
		faults = f;
		uartWrite = uw;
		uartWriteData = wd;
		nvmWrite = '{nv, seed[15:8], seed[23:16]};
		lat = (uw ? wd : lat) & ERR_LATCH;
		lat |= {1'b0, f[0] | (nvd == 2 && corrupt), 1'b0, f[1], f[2], f[3], 1'b0, f[5]};
		expByte = lat | {2'b0, oorD, 3'b0, f[4], 1'b0};
		oorD = oor;
	endtask : step
	initial begin
		{rst, selfTestFail, uartWrite, uartWriteData, corrupt, oorD} = '1;
		faults = '0;
		nvmWrite = '0;
		seed = 32'h07c2;
		for (int i = 0; i < NUM_PROBES; i++) probe[i] = '{16'h4000, 16'h0100, 16'hfeff};
		for (int k = 0; k < 2; k++) begin
			selfTestFail = (k == 0);
			{rst, uartWrite, corrupt, oorD} = 4'h8;
			repeat (2) @(negedge clk);
			rst = 1'b0;
			for (int n = 0; n < 60 && selfTestDone !== 1'b1; n++) @(negedge clk);
			@(negedge clk);
			lat = {7'h0, k == 0};
			expByte = lat;
			chk8(uartReadData, lat);
			chk8({7'h0, statusOk}, {7'h0, k == 1});
			chk8({7'h0, selfTestRun}, 8'h00);
		end
		repeat (400) begin
			seed = xs(seed);
			step(seed[5:0] & seed[13:8] & seed[21:16], seed[22] & seed[23], seed[31:24], 1'b0);
		end
		step(6'h0, 1'b1, 8'h00, 1'b0);
		for (int c = 0; c < 2; c++) begin
			corrupt = c[0];
			step(6'h0, 1'b0, 8'h00, 1'b1);
			repeat (5) step(6'h0, 1'b0, 8'h00, 1'b0);
		end
		end_of_test();
	end
endmodule : error_status_aggregator_tb
